// file: hdl/vie_entry.v
// vectored and non-maskable interrupt entry sequencer with wishbone registers
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "vie_regs.vh"
module vie_entry (
    input wire clock,
    input wire reset_n,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire [`VIE_NUM_SRC-1:0] srcReq,
    input wire nmi_n,
    output reg [23:0] memAddr,
    output reg [7:0] memWrData,
    output reg memWe,
    output reg memReq,
    input wire memAck,
    input wire [7:0] memRdData,
    output wire entryActive,
    output wire [23:0] effectivePc,
    output wire wideModeOut
);
    localparam ST_IDLE = 2'd0;
    localparam ST_PUSH = 2'd1;
    localparam ST_RDLO = 2'd2;
    localparam ST_RDHI = 2'd3;

    // architectural context
    reg interrupt_enable_flag_one_q;
    reg interrupt_enable_flag_two_q;
    reg wide_address_mode_bit_q;
    reg mixed_mode_flag_q;
    reg [7:0] page_base_byte_q;
    reg [7:0] intPage_q;
    reg [23:0] pc_q;
    reg [15:0] short_stack_pointer_q;
    reg [23:0] long_stack_pointer_q;

    // sequencer state
    reg [1:0] state_q;
    reg [31:0] pushBytes_q;
    reg [2:0] pushLeft_q;
    reg useLong_q;
    reg isNmi_q;
    reg [7:0] vec_q;
    reg [7:0] tableBase_q;
    reg [7:0] lowByte_q;
    reg nmiArmed_q;
    reg nmiTaken_q;
    reg [15:0] entryCnt_q;

    wire irqValid;
    wire [7:0] vectorLowBus;
    wire nmiSync;

    vie_vec_arb u_arb (
        .clock(clock),
        .reset_n(reset_n),
        .srcReq(srcReq),
        .irqValid(irqValid),
        .vectorLowBus(vectorLowBus)
    );

    vie_sync #(
        .RESET_VAL(1'b1)
    ) u_nmi_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pinIn(nmi_n),
        .pinSync(nmiSync)
    );

    // request decode in idle; non-maskable first and never gated
    wire idle = (state_q == ST_IDLE);
    wire nmiReq = ~nmiSync & nmiArmed_q;
    wire takeNmi = idle & nmiReq;
    wire takeIrq = idle & ~nmiReq & irqValid & interrupt_enable_flag_one_q;
    wire accept = takeNmi | takeIrq;
    wire bothClear = ~wide_address_mode_bit_q & ~mixed_mode_flag_q;
    wire memDone = memReq & memAck;

    // bus slave decode
    wire wbReq = wb_cyc_i & wb_stb_i;
    wire wbWrite = wbReq & wb_we_i & wb_ack_o & idle;
    wire [31:0] wMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function [31:0] merge;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [31:0] mask;
        begin
            merge = (oldVal & ~mask) | (newVal & mask);
        end
    endfunction

    wire [31:0] ctrlRd = {28'h0000000, mixed_mode_flag_q, wide_address_mode_bit_q,
                          interrupt_enable_flag_two_q, interrupt_enable_flag_one_q};
    wire [31:0] pageRd = {16'h0000, intPage_q, page_base_byte_q};
    wire [31:0] statRd = {entryCnt_q, lowByte_q, 6'h00, nmiTaken_q, ~idle};
    wire [31:0] ctrlNew = merge(ctrlRd, wb_dat_i, wMask);
    wire [31:0] pageNew = merge(pageRd, wb_dat_i, wMask);
    wire [31:0] pcNew = merge({8'h00, pc_q}, wb_dat_i, wMask);
    wire [31:0] spsNew = merge({16'h0000, short_stack_pointer_q}, wb_dat_i, wMask);
    wire [31:0] splNew = merge({8'h00, long_stack_pointer_q}, wb_dat_i, wMask);

    // read mux; unmapped offsets read zero
    reg [31:0] rdData;
    always @* begin
        case (wb_adr_i)
            `VIE_OFS_CTRL: rdData = ctrlRd;
            `VIE_OFS_PAGE: rdData = pageRd;
            `VIE_OFS_PC: rdData = {8'h00, pc_q};
            `VIE_OFS_SSTK: rdData = {16'h0000, short_stack_pointer_q};
            `VIE_OFS_LSTK: rdData = {8'h00, long_stack_pointer_q};
            `VIE_OFS_STATUS: rdData = statRd;
            default: rdData = 32'h00000000;
        endcase
    end

    // ack one cycle after the strobe, dropped the cycle after
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wbReq & ~wb_ack_o;
            wb_dat_o <= (wbReq & ~wb_ack_o) ? rdData : 32'h00000000;
        end
    end

    // byte order popped from the low end of the push list
    wire [31:0] wideList = {mixed_mode_flag_q ? `VIE_MARK_WIDE : 8'h00,
                            pc_q[7:0], pc_q[15:8], pc_q[23:16]};
    wire [31:0] shortList = {8'h00, mixed_mode_flag_q ? `VIE_MARK_COMPAT : 8'h00,
                             pc_q[7:0], pc_q[15:8]};
    wire [2:0] pushCount = (wide_address_mode_bit_q ? 3'd3 : 3'd2) +
                           (mixed_mode_flag_q ? 3'd1 : 3'd0);
    wire [15:0] spsDec = short_stack_pointer_q - 16'h0001;
    wire [23:0] splDec = long_stack_pointer_q - 24'h000001;

    // sequencer: context writes by software, hardware overrides
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            interrupt_enable_flag_one_q <= 1'b0;
            interrupt_enable_flag_two_q <= 1'b0;
            wide_address_mode_bit_q <= 1'b0;
            mixed_mode_flag_q <= 1'b0;
            page_base_byte_q <= `VIE_RST_BYTE;
            intPage_q <= `VIE_RST_BYTE;
            pc_q <= `VIE_RST_PC;
            short_stack_pointer_q <= `VIE_RST_SSTK;
            long_stack_pointer_q <= `VIE_RST_LSTK;
            pushBytes_q <= 32'h00000000;
            pushLeft_q <= 3'd0;
            useLong_q <= 1'b0;
            isNmi_q <= 1'b0;
            vec_q <= 8'h00;
            tableBase_q <= 8'h00;
            lowByte_q <= 8'h00;
            nmiArmed_q <= 1'b1;
            nmiTaken_q <= 1'b0;
            entryCnt_q <= 16'h0000;
            memAddr <= 24'h000000;
            memWrData <= 8'h00;
            memWe <= 1'b0;
            memReq <= 1'b0;
        end else begin
            // software access, only while no entry runs
            if (wbWrite) begin
                case (wb_adr_i)
                    `VIE_OFS_CTRL: begin
                        interrupt_enable_flag_one_q <= ctrlNew[`VIE_CTRL_EN1];
                        interrupt_enable_flag_two_q <= ctrlNew[`VIE_CTRL_EN2];
                        wide_address_mode_bit_q <= ctrlNew[`VIE_CTRL_WIDE];
                        mixed_mode_flag_q <= ctrlNew[`VIE_CTRL_MIXED];
                    end
                    `VIE_OFS_PAGE: begin
                        page_base_byte_q <= pageNew[7:0];
                        intPage_q <= pageNew[15:8];
                    end
                    `VIE_OFS_PC: pc_q <= pcNew[23:0];
                    `VIE_OFS_SSTK: short_stack_pointer_q <= spsNew[15:0];
                    `VIE_OFS_LSTK: long_stack_pointer_q <= splNew[23:0];
                    default: ;
                endcase
            end
            // re-arm the pin only after it has gone high again
            if (nmiSync) begin
                nmiArmed_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_PUSH;
                        useLong_q <= wide_address_mode_bit_q | mixed_mode_flag_q;
                        pushBytes_q <= wide_address_mode_bit_q ? wideList : shortList;
                        pushLeft_q <= pushCount;
                        tableBase_q <= bothClear ? page_base_byte_q : `VIE_PAGE_ZERO;
                        isNmi_q <= takeNmi;
                        nmiTaken_q <= takeNmi;
                        entryCnt_q <= entryCnt_q + 16'h0001;
                        interrupt_enable_flag_one_q <= 1'b0;
                        if (takeNmi) begin
                            nmiArmed_q <= 1'b0;
                        end else begin
                            vec_q <= vectorLowBus;
                            lowByte_q <= vectorLowBus;
                            interrupt_enable_flag_two_q <= 1'b0;
                        end
                    end
                end
                ST_PUSH: begin
                    if (!memReq) begin
                        // pre-decrement: stack grows downward
                        memReq <= 1'b1;
                        memWe <= 1'b1;
                        memWrData <= pushBytes_q[7:0];
                        memAddr <= useLong_q ? splDec
                                             : {page_base_byte_q, spsDec};
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        memWe <= 1'b0;
                        pushBytes_q <= {8'h00, pushBytes_q[31:8]};
                        pushLeft_q <= pushLeft_q - 3'd1;
                        if (useLong_q) begin
                            long_stack_pointer_q <= splDec;
                        end else begin
                            short_stack_pointer_q <= spsDec;
                        end
                        if (pushLeft_q == 3'd1) begin
                            if (isNmi_q) begin
                                // fixed target, no table fetch
                                state_q <= ST_IDLE;
                                pc_q <= {`VIE_PAGE_ZERO, `VIE_NMI_TARGET};
                                if (mixed_mode_flag_q) begin
                                    wide_address_mode_bit_q <= 1'b1;
                                end
                            end else begin
                                state_q <= ST_RDLO;
                            end
                        end
                    end
                end
                ST_RDLO: begin
                    // low byte of the target sits at the lower address
                    if (!memReq) begin
                        memReq <= 1'b1;
                        memWe <= 1'b0;
                        memAddr <= {tableBase_q, intPage_q, vec_q};
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        lowByte_q <= memRdData;
                        state_q <= ST_RDHI;
                    end
                end
                ST_RDHI: begin
                    if (!memReq) begin
                        memReq <= 1'b1;
                        memWe <= 1'b0;
                        memAddr <= {tableBase_q, intPage_q, vec_q + 8'h01};
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        state_q <= ST_IDLE;
                        // upper byte is zero; short modes view it through the page base
                        pc_q <= {`VIE_PAGE_ZERO, memRdData, lowByte_q};
                        lowByte_q <= vec_q;
                        if (mixed_mode_flag_q) begin
                            wide_address_mode_bit_q <= 1'b1;
                        end else begin
                            wide_address_mode_bit_q <= wide_address_mode_bit_q;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // short modes see the program counter through the page base
    // registered, so it trails a context change by one cycle
    reg [23:0] effPc_q;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            effPc_q <= `VIE_RST_PC;
        end else begin
            effPc_q <= wide_address_mode_bit_q ? pc_q
                                               : {page_base_byte_q, pc_q[15:0]};
        end
    end
    assign effectivePc = effPc_q;
    assign entryActive = ~idle;
    assign wideModeOut = wide_address_mode_bit_q;
endmodule // vie_entry

// file: shared/vie_regs.vh
// register offsets, field positions and constants of the interrupt entry sequencer
`ifndef VIE_REGS_VH
`define VIE_REGS_VH

// wishbone byte offsets, one 32-bit word each
`define VIE_OFS_CTRL 8'h00
`define VIE_OFS_PAGE 8'h04
`define VIE_OFS_PC 8'h08
`define VIE_OFS_SSTK 8'h0C
`define VIE_OFS_LSTK 8'h10
`define VIE_OFS_STATUS 8'h14

// control register fields
`define VIE_CTRL_EN1 0
`define VIE_CTRL_EN2 1
`define VIE_CTRL_WIDE 2
`define VIE_CTRL_MIXED 3

// status register fields
`define VIE_STAT_BUSY 0
`define VIE_STAT_NMI 1
`define VIE_STAT_VEC_LSB 8
`define VIE_STAT_CNT_LSB 16

// reset values
`define VIE_RST_CTRL 4'h0
`define VIE_RST_BYTE 8'h00
`define VIE_RST_PC 24'h000000
`define VIE_RST_SSTK 16'h0000
`define VIE_RST_LSTK 24'h000000

// entry constants
`define VIE_NUM_SRC 48
`define VIE_PAGE_ZERO 8'h00
`define VIE_MARK_COMPAT 8'h00
`define VIE_MARK_WIDE 8'h01
`define VIE_NMI_TARGET 16'h0066

`endif

// file: hdl/vie_sync.v
// two flip-flop synchroniser for an asynchronous pin
`timescale 1ns/10ps
module vie_sync #(
    parameter RESET_VAL = 1'b1
) (
    input wire clock,
    input wire reset_n,
    input wire pinIn,
    output wire pinSync
);
    reg meta_q;
    reg sync_q;

    // first stage feeds only the second stage
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
        end
    end

    assign pinSync = sync_q;
endmodule // vie_sync

// file: hdl/vie_vec_arb.v
// fixed priority resolver that drives the eight-bit vector bus
`timescale 1ns/10ps
`include "vie_regs.vh"
module vie_vec_arb (
    input wire clock,
    input wire reset_n,
    input wire [`VIE_NUM_SRC-1:0] srcReq,
    output reg irqValid,
    output reg [7:0] vectorLowBus
);
    wire [`VIE_NUM_SRC:0] seen;
    wire [7:0] pick [0:`VIE_NUM_SRC];

    assign seen[0] = 1'b0;
    assign pick[0] = 8'h00;

    // lowest index wins; its vector is twice its index
    genvar i;
    generate
        for (i = 0; i < `VIE_NUM_SRC; i = i + 1) begin : g_src
            localparam [31:0] OWN_W = i * 2;
            wire [7:0] own = OWN_W[7:0];
            assign seen[i+1] = seen[i] | srcReq[i];
            assign pick[i+1] = pick[i] | ((srcReq[i] & ~seen[i]) ? own : 8'h00);
        end
    endgenerate

    // valid and vector change together, both registered one cycle after the request, so the bus never lags the valid flag
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqValid <= 1'b0;
            vectorLowBus <= 8'h00;
        end else begin
            irqValid <= seen[`VIE_NUM_SRC];
            vectorLowBus <= pick[`VIE_NUM_SRC];
        end
    end
endmodule // vie_vec_arb

// file: bench/vie_mem_model.sv
// byte memory model standing on the sequencer's stack and table port
`timescale 1ns/10ps
module vie_mem_model (
    input wire clock,
    input wire reset_n,
    input wire [23:0] memAddr,
    input wire [7:0] memWrData,
    input wire memWe,
    input wire memReq,
    input wire [3:0] waitCycles,
    output logic memAck,
    output logic [7:0] memRdData
);
    logic [7:0] mem [logic [23:0]];
    logic [3:0] cnt_q;
    // answer after waitCycles; read data toggles outside the ack so stale bytes never pass
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            memAck <= 1'b0;
            cnt_q <= 4'h0;
            memRdData <= 8'h5A;
        end else if (memReq && !memAck && cnt_q >= waitCycles) begin
            memAck <= 1'b1;
            cnt_q <= 4'h0;
            if (memWe) mem[memAddr] = memWrData;
            else memRdData <= mem.exists(memAddr) ? mem[memAddr] : 8'hEE;
        end else begin
            memAck <= 1'b0;
            cnt_q <= (memReq && !memAck) ? cnt_q + 4'h1 : 4'h0;
            memRdData <= ~memRdData;
        end
    end
endmodule // vie_mem_model

// file: bench/vie_entry_chk.sv
// port-level assertions for the interrupt entry sequencer
`timescale 1ns/10ps
module vie_entry_chk (
    input wire clock,
    input wire reset_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire nmi_n,
    input wire [23:0] memAddr,
    input wire [7:0] memWrData,
    input wire memWe,
    input wire memReq,
    input wire memAck,
    input wire entryActive,
    input wire [23:0] effectivePc,
    input wire wideModeOut
);
    reg pushDone_q;
    // set once a push of this entry completed; tells the first push apart
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pushDone_q <= 1'b0;
        end else begin
            pushDone_q <= entryActive && (pushDone_q || (memReq && memAck && memWe));
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    read_data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");
    mem_req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
        && $stable(memWe) && $stable(memWrData)) else $error("memory request changed early");
    mem_req_drop_a: assert property (memReq && memAck |=> !memReq)
        else $error("memory request not dropped");
    mem_idle_quiet_a: assert property (!entryActive |-> !memReq)
        else $error("memory access while idle");
    wide_bit_kept_a: assert property (entryActive && wideModeOut |=> wideModeOut)
        else $error("wide bit cleared during entry");
    first_push_data_a: assert property (memReq && memWe && !pushDone_q |->
        memWrData == (wideModeOut ? effectivePc[23:16] : effectivePc[15:8]))
        else $error("first pushed byte wrong");
    read_after_push_a: assert property (memReq && !memWe |-> pushDone_q)
        else $error("table read before push");
    nmi_entry_a: assert property ($fell(nmi_n) && !entryActive |-> ##[1:6] entryActive)
        else $error("low nmi pin started no entry");
    cover property (memReq && memAck && !memWe);
    cover property (memReq && !memAck ##1 memReq && !memAck);
    cover property ($fell(entryActive));
endmodule // vie_entry_chk

bind vie_entry vie_entry_chk vie_entry_chk_i (.clock(clock), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .nmi_n(nmi_n), .memAddr(memAddr), .memWrData(memWrData), .memWe(memWe),
    .memReq(memReq), .memAck(memAck), .entryActive(entryActive),
    .effectivePc(effectivePc), .wideModeOut(wideModeOut));

// file: bench/vie_entry_bench.sv
// self-checking bench for the interrupt entry sequencer
`timescale 1ns/10ps
`include "vie_regs.vh"
module vie_entry_bench;
    logic clock = 1'b0;
    logic resetN = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h00000000;
    logic wbWe = 1'b0;
    logic [3:0] wbSel = 4'hF;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic [`VIE_NUM_SRC-1:0] srcReq = {`VIE_NUM_SRC{1'b0}};
    logic nmiN = 1'b1;
    logic [3:0] waitCycles = 4'h0;
    logic [31:0] wbDatR, rd;
    logic wbAck, memWe, memReq, memAck, entryActive, wideModeOut, wide, mixed;
    logic [23:0] memAddr, effectivePc, sp;
    logic [7:0] memWrData, memRdData, vec, tb;
    logic [7:0] pushExp [5];
    int mismatches = 0;
    int numChecks = 0;
    int n, src;
    vie_entry vie_entry_i (.clock(clock), .reset_n(resetN), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_sel_i(wbSel), .wb_we_i(wbWe),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck), .srcReq(srcReq), .nmi_n(nmiN),
        .memAddr(memAddr), .memWrData(memWrData), .memWe(memWe), .memReq(memReq),
        .memAck(memAck), .memRdData(memRdData), .entryActive(entryActive),
        .effectivePc(effectivePc), .wideModeOut(wideModeOut));
    vie_mem_model vie_mem_model_i (.clock(clock), .reset_n(resetN), .memAddr(memAddr),
        .memWrData(memWrData), .memWe(memWe), .memReq(memReq), .waitCycles(waitCycles),
        .memAck(memAck), .memRdData(memRdData));
    always #25 clock = ~clock;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chkW(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkB(input string what, input logic [7:0] exp, input logic [7:0] got);
        chkW(what, {24'h000000, exp}, {24'h000000, got});
    endtask
    function automatic logic [7:0] memGet(input logic [23:0] a);
        return vie_mem_model_i.mem.exists(a) ? vie_mem_model_i.mem[a] : 8'hEE;
    endfunction
    // one classic cycle: hold until ack is sampled, take data there, then idle a cycle
    task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] dat);
        int w;
        w = 0;
        wbAdr <= adr;
        wbWe <= we;
        wbDatW <= dat;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        @(posedge clock);
        while (wbAck !== 1'b1 && w < 50) begin
            @(posedge clock);
            w++;
        end
        rd = wbDatR;
        chkW("bus ack", 32'h00000001, {31'h00000000, wbAck});
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clock);
    endtask
    // bounded wait for an entry to start and to finish
    task automatic waitEntry();
        int w;
        w = 0;
        while (entryActive !== 1'b1 && w < 100) begin
            @(posedge clock);
            w++;
        end
        chkW("entry start", 32'h00000001, {31'h00000000, w < 100});
        while (entryActive !== 1'b0 && w < 500) begin
            @(posedge clock);
            w++;
        end
        chkW("entry end", 32'h00000001, {31'h00000000, w < 500});
    endtask
    initial begin
        #(50 * 40000);
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clock);
        resetN <= 1'b1;
        @(posedge clock);
        // reset words, unmapped word and read-only status
        for (int a = 0; a < 7; a++) begin
            wb(8'(a * 4), 1'b0, 32'h00000000);
            chkW("reset word", 32'h00000000, rd);
        end
        wb(8'h18, 1'b1, 32'hFFFFFFFF);
        wb(`VIE_OFS_STATUS, 1'b1, 32'hFFFFFFFF);
        wb(8'h18, 1'b0, 32'h00000000);
        chkW("unmapped", 32'h00000000, rd);
        wb(`VIE_OFS_STATUS, 1'b0, 32'h00000000);
        chkW("status ro", 32'h00000000, rd);
        // byte lanes: only lane one of the page word may change
        wbSel <= 4'h2;
        wb(`VIE_OFS_PAGE, 1'b1, 32'h0000A5C3);
        wbSel <= 4'hF;
        wb(`VIE_OFS_PAGE, 1'b0, 32'h00000000);
        chkW("page lanes", 32'h0000A500, rd);
        wb(`VIE_OFS_PAGE, 1'b1, 32'h00001234);
        // maskable entry in all four mode combinations, memory ever slower
        for (int k = 0; k < 4; k++) begin
            wide = k[0];
            mixed = k[1];
            src = k * 5 + 1;
            vec = 8'(src * 2);
            tb = (k == 0) ? 8'h34 : 8'h00;
            sp = (k == 0) ? 24'h340100 : 24'h020200;
            waitCycles <= 4'(k * 3);
            vie_mem_model_i.mem.delete();
            vie_mem_model_i.mem[{tb, 8'h12, vec}] = 8'hC0 + 8'(k);
            vie_mem_model_i.mem[{tb, 8'h12, vec + 8'h01}] = 8'h90 + 8'(k);
            wb(`VIE_OFS_PC, 1'b1, 32'h00AB5678);
            wb(`VIE_OFS_SSTK, 1'b1, 32'h00000100);
            wb(`VIE_OFS_LSTK, 1'b1, 32'h00020200);
            wb(`VIE_OFS_CTRL, 1'b1, {28'h0000000, mixed, wide, 2'b11});
            // the effective address output is registered: let it settle
            @(posedge clock);
            chkW("pc before", wide ? 32'h00AB5678 : 32'h00345678, {8'h00, effectivePc});
            srcReq[src] <= 1'b1;
            waitEntry();
            srcReq[src] <= 1'b0;
            n = wide ? 1 : 0;
            pushExp[0] = 8'hAB;
            pushExp[n] = 8'h56;
            pushExp[n + 1] = 8'h78;
            pushExp[n + 2] = {7'h00, wide};
            n = n + (mixed ? 3 : 2);
            pushExp[n] = 8'hEE;
            for (int j = 0; j <= n; j++) begin
                chkB("stack", pushExp[j], memGet(sp - 24'(j + 1)));
            end
            wb(`VIE_OFS_CTRL, 1'b0, 32'h00000000);
            chkW("ctrl", {28'h0000000, mixed, wide | mixed, 2'b00}, rd);
            chkW("wide out", {31'h00000000, wide | mixed}, {31'h00000000, wideModeOut});
            wb(`VIE_OFS_PC, 1'b0, 32'h00000000);
            chkW("pc", {16'h0000, 8'h90 + 8'(k), 8'hC0 + 8'(k)}, rd);
            chkW("eff pc", {8'h00, tb, 8'h90 + 8'(k), 8'hC0 + 8'(k)}, {8'h00, effectivePc});
            wb(`VIE_OFS_STATUS, 1'b0, 32'h00000000);
            chkW("status", {16'(k + 1), vec, 8'h00}, rd);
        end
        // pin entry against a pending maskable request, with and without flags
        for (int k = 0; k < 2; k++) begin
            vie_mem_model_i.mem.delete();
            wb(`VIE_OFS_PC, 1'b1, 32'h00001122);
            wb(`VIE_OFS_SSTK, 1'b1, 32'h00000100);
            wb(`VIE_OFS_CTRL, 1'b1, k ? 32'h00000000 : 32'h00000003);
            nmiN <= 1'b0;
            @(posedge clock);
            srcReq[3] <= 1'b1;
            waitEntry();
            wb(`VIE_OFS_PC, 1'b0, 32'h00000000);
            chkW("nmi pc", 32'h00000066, rd);
            wb(`VIE_OFS_CTRL, 1'b0, 32'h00000000);
            chkW("nmi ctrl", k ? 32'h00000000 : 32'h00000002, rd);
            chkB("nmi hi", 8'h11, memGet(24'h3400FF));
            chkB("nmi lo", 8'h22, memGet(24'h3400FE));
            wb(`VIE_OFS_STATUS, 1'b0, 32'h00000000);
            chkW("nmi status", {16'(5 + k), 16'h0002}, rd & 32'hFFFF00FF);
            repeat (20) @(posedge clock);
            chkW("masked", 32'h00000000, {31'h00000000, entryActive});
            nmiN <= 1'b1;
            srcReq[3] <= 1'b0;
            repeat (4) @(posedge clock);
        end
        end_sim();
    end
endmodule // vie_entry_bench
